/* hw/gate_seq_pkg.sv */
// constants for the gate pulse sequencer: widths, timing counts, step modes
// assumes a single 100 MHz timing clock; all times are counted in its cycles
//
// How it works
// - pulse trains need the delay pulse generator gate mode
// - intensifier pulses repeatedly, sensor read once
// - first set uses programmed delays and widths
// - delays timed from strobe or trigger edge
// - later sets start one period after previous
// - period raised to span of all pulses
// - fill option runs as many sets as fit
// - explicit count gives exactly that many sets
// - internal trains add at least 20 ns delay
// - repetition period set in 20 ns steps
// - external trigger: one pulse per edge
// - stepping only in kinetic series, per output
// - frame one base, later frames base plus step
// - positive step later, negative step earlier
// - delay and width step modes chosen independently
// - modes take one or two coefficients; code: constant takes one increment, exponential uses the host-loaded table
// - constant step: (n-1) times increment
// - exponential step: A*exp(B*(n-1)), frame one zero; code reads each frame's step from the host-loaded table
package gate_seq_pkg;
	// ==========================================
	// widths
	localparam int TW = 24;
	localparam int CHANS = 4;
	localparam int AUX = 3;
	localparam int PC_W = 8;
	localparam int FRAME_W = 6;
	localparam int FRAMES = 64;

	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MPI_EXTRA_NS = 20;
	localparam int MPI_EXTRA_CYC = (MPI_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PERIOD_STEP_NS = 20;
	localparam int PERIOD_STEP_CYC = PERIOD_STEP_NS / CLK_PERIOD_NS;

	// ==========================================
	// step modes
	localparam logic [1:0] STEP_OFF = 2'h0;
	localparam logic [1:0] STEP_CONST = 2'h1;
	localparam logic [1:0] STEP_EXP = 2'h2;

	// ==========================================
	// reset values
	localparam logic [TW-1:0] TIME_RST = 24'h000000;
	localparam logic [FRAME_W-1:0] FRAME_RST = 6'h00;
	localparam logic [PC_W-1:0] COUNT_RST = 8'h00;
endpackage

/* hw/gate_pulse_train_and_step.sv */
// gate pulse sequencer: multi-pulse trains per exposure and per-frame stepping
// assumes exposure_on and ext_trig_in are already synchronous to ref_clk
`timescale 1ns/1ps
module gate_pulse_train_and_step (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// mode selection
	input wire logic gate_mode_ddg,
	input wire logic multi_pulse_integration,
	input wire logic ext_trig_mode,
	input wire logic ext_edge_falling,
	input wire logic fill_exposure_option,
	input wire logic [gate_seq_pkg::PC_W-1:0] pulse_set_count,
	input wire logic [gate_seq_pkg::TW-1:0] period_steps,
	input wire logic [gate_seq_pkg::TW-1:0] exposure_cycles,
	// channel timing, index 0 is the intensifier gate
	input wire logic [gate_seq_pkg::CHANS-1:0] ch_enable,
	input wire logic [gate_seq_pkg::CHANS-1:0] ch_step_enable,
	input wire logic [gate_seq_pkg::CHANS-1:0][gate_seq_pkg::TW-1:0] ch_delay,
	input wire logic [gate_seq_pkg::CHANS-1:0][gate_seq_pkg::TW-1:0] ch_width,
	// per-frame stepping
	input wire logic kinetic_series,
	input wire logic series_start,
	input wire logic [1:0] delay_step_mode,
	input wire logic [1:0] width_step_mode,
	input wire logic signed [gate_seq_pkg::TW-1:0] delay_step_inc,
	input wire logic signed [gate_seq_pkg::TW-1:0] width_step_inc,
	input wire logic tab_we,
	input wire logic tab_width_sel,
	input wire logic [gate_seq_pkg::FRAME_W-1:0] tab_addr,
	input wire logic signed [gate_seq_pkg::TW-1:0] tab_data,
	// sensor and trigger
	input wire logic exposure_on,
	input wire logic ext_trig_in,
	// outputs
	output logic gate_out,
	output logic [gate_seq_pkg::AUX-1:0] aux_out,
	output logic readout_req,
	output logic busy,
	output logic [gate_seq_pkg::FRAME_W-1:0] frame_index
);
	localparam int TW = gate_seq_pkg::TW;
	localparam int CH = gate_seq_pkg::CHANS;

	typedef enum {S_IDLE, S_RUN} seq_state_t;

	// ==========================================
	// state
	seq_state_t state_reg, state_next;
	logic expo_prev_reg, trig_prev_reg;
	logic [TW-1:0] t_reg, t_next;
	logic [TW-1:0] remain_reg, remain_next;
	logic [gate_seq_pkg::PC_W-1:0] sets_left_reg, sets_left_next;
	logic fill_reg, fill_next;
	logic [CH-1:0][TW-1:0] start_reg, start_next;
	logic [CH-1:0][TW-1:0] end_reg, end_next;
	logic [gate_seq_pkg::FRAME_W-1:0] frame_reg, frame_next;
	logic signed [TW-1:0] acc_d_reg, acc_d_next, acc_w_reg, acc_w_next;
	logic gate_reg, gate_next;
	logic [gate_seq_pkg::AUX-1:0] aux_reg, aux_next;
	logic readout_reg, readout_next;
	logic busy_reg, busy_next;
	// host-loaded exponential steps, one word per frame
	logic signed [TW-1:0] tab_d [gate_seq_pkg::FRAMES];
	logic signed [TW-1:0] tab_w [gate_seq_pkg::FRAMES];

	// ==========================================
	// decode
	logic fire, expo_fall, ext_edge, mpi_on, ext_start, next_ok;
	logic [TW-1:0] extra, span, period_cyc, eff_period, min_start, max_end, phase;
	logic [TW:0] wrap_at;
	logic signed [TW-1:0] step_d, step_w;
	logic [CH-1:0] ch_on;

	function automatic logic signed [TW-1:0] pick_step(input logic [1:0] mode, input logic signed [TW-1:0] acc,
			input logic signed [TW-1:0] tabv);
		logic signed [TW-1:0] s;
		s = '0;
		if (mode == gate_seq_pkg::STEP_CONST) begin
			s = acc;
		end else if (mode == gate_seq_pkg::STEP_EXP) begin
			s = tabv;
		end
		return s;
	endfunction

	// negative sums clamp to zero so the gate can never open before the edge
	function automatic logic [TW-1:0] apply_step(input logic [TW-1:0] base, input logic signed [TW-1:0] s,
			input logic [TW-1:0] add);
		logic signed [TW+1:0] sum;
		sum = $signed({2'b00, base}) + $signed({s[TW-1], s[TW-1], s}) + $signed({2'b00, add});
		return sum[TW+1] ? '0 : (sum[TW] ? '1 : sum[TW-1:0]);
	endfunction

	always_comb begin
		fire = exposure_on & ~expo_prev_reg;
		expo_fall = ~exposure_on & expo_prev_reg;
		ext_edge = ext_edge_falling ? (trig_prev_reg & ~ext_trig_in) : (~trig_prev_reg & ext_trig_in);
		mpi_on = multi_pulse_integration & gate_mode_ddg & ~ext_trig_mode;
		extra = mpi_on ? TW'(gate_seq_pkg::MPI_EXTRA_CYC) : '0;
		ext_start = ext_trig_mode & exposure_on & expo_prev_reg & ext_edge & (state_reg == S_IDLE);
		// first frame and non-kinetic runs use the base values
		if (kinetic_series && frame_reg != gate_seq_pkg::FRAME_RST) begin
			step_d = pick_step(delay_step_mode, acc_d_reg, tab_d[frame_reg]);
			step_w = pick_step(width_step_mode, acc_w_reg, tab_w[frame_reg]);
		end else begin
			step_d = '0;
			step_w = '0;
		end
		min_start = '1;
		max_end = '0;
		for (int i = 0; i < CH; i++) begin
			if (ch_enable[i] && start_reg[i] < min_start) begin
				min_start = start_reg[i];
			end
			if (ch_enable[i] && end_reg[i] > max_end) begin
				max_end = end_reg[i];
			end
		end
		span = (max_end > min_start) ? max_end - min_start : '0;
		// later sets restart at the earliest start so each set begins exactly one period after the previous one
		phase = (max_end > min_start) ? min_start : '0;
		period_cyc = TW'(period_steps * TW'(gate_seq_pkg::PERIOD_STEP_CYC));
		eff_period = (period_cyc > span) ? period_cyc : span;
		if (eff_period == '0) begin
			eff_period = TW'(1);
		end
		wrap_at = {1'b0, phase} + {1'b0, eff_period} - (TW+1)'(1);
		next_ok = exposure_on && (remain_reg > span) && (fill_reg || sets_left_reg != '0);
	end

	// ==========================================
	// per-channel pulse windows
	generate
		for (genvar g = 0; g < CH; g++) begin : g_chan
			logic signed [TW-1:0] sd, sw;
			logic [TW-1:0] d_eff;
			assign sd = ch_step_enable[g] ? step_d : '0;
			assign sw = ch_step_enable[g] ? step_w : '0;
			assign d_eff = apply_step(ch_delay[g], sd, extra);
			assign start_next[g] = fire ? d_eff : start_reg[g];
			assign end_next[g] = fire ? apply_step(d_eff, '0, apply_step(ch_width[g], sw, '0)) : end_reg[g];
			assign ch_on[g] = (state_reg == S_RUN) && ch_enable[g] && t_reg >= start_reg[g] && t_reg < end_reg[g];
		end
	endgenerate

	// ==========================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		t_next = t_reg + TW'(1);
		sets_left_next = sets_left_reg;
		fill_next = fill_reg;
		remain_next = (exposure_on && remain_reg != '0) ? remain_reg - TW'(1) : remain_reg;
		if (fire) begin
			remain_next = exposure_cycles;
		end
		case (state_reg)
			S_IDLE: begin
				t_next = '0;
				if (fire && !ext_trig_mode) begin
					state_next = S_RUN;
					fill_next = mpi_on & fill_exposure_option;
					sets_left_next = (mpi_on && pulse_set_count != '0) ? pulse_set_count - 8'h01 : '0;
				end else if (ext_start) begin
					state_next = S_RUN;
					fill_next = 1'b0;
					sets_left_next = '0;
				end
			end
			S_RUN: begin
				if ({1'b0, t_reg} >= wrap_at) begin
					t_next = phase;
					if (next_ok) begin
						sets_left_next = fill_reg ? sets_left_reg : sets_left_reg - 8'h01;
					end else begin
						state_next = S_IDLE;
						fill_next = 1'b0;
						sets_left_next = '0;
					end
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// ==========================================
	// frame stepping
	always_comb begin
		frame_next = frame_reg;
		acc_d_next = acc_d_reg;
		acc_w_next = acc_w_reg;
		if (series_start) begin
			frame_next = gate_seq_pkg::FRAME_RST;
			acc_d_next = '0;
			acc_w_next = '0;
		end else if (fire && kinetic_series) begin
			frame_next = (frame_reg == '1) ? frame_reg : frame_reg + 6'h01;
			acc_d_next = acc_d_reg + delay_step_inc;
			acc_w_next = acc_w_reg + width_step_inc;
		end
	end

	// ==========================================
	// outputs
	always_comb begin
		gate_next = ch_on[0];
		aux_next = ch_on[CH-1:1];
		readout_next = expo_fall;
		busy_next = (state_next == S_RUN);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			expo_prev_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
			t_reg <= gate_seq_pkg::TIME_RST;
			remain_reg <= gate_seq_pkg::TIME_RST;
			sets_left_reg <= gate_seq_pkg::COUNT_RST;
			fill_reg <= 1'b0;
			start_reg <= '0;
			end_reg <= '0;
			frame_reg <= gate_seq_pkg::FRAME_RST;
			acc_d_reg <= '0;
			acc_w_reg <= '0;
			gate_reg <= 1'b0;
			aux_reg <= '0;
			readout_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			expo_prev_reg <= exposure_on;
			trig_prev_reg <= ext_trig_in;
			t_reg <= t_next;
			remain_reg <= remain_next;
			sets_left_reg <= sets_left_next;
			fill_reg <= fill_next;
			start_reg <= start_next;
			end_reg <= end_next;
			frame_reg <= frame_next;
			acc_d_reg <= acc_d_next;
			acc_w_reg <= acc_w_next;
			gate_reg <= gate_next;
			aux_reg <= aux_next;
			readout_reg <= readout_next;
			busy_reg <= busy_next;
		end
	end

	// table is plain storage; host writes it before the run starts
	always_ff @(posedge ref_clk) begin
		if (tab_we && tab_width_sel) begin
			tab_w[tab_addr] <= tab_data;
		end
		if (tab_we && !tab_width_sel) begin
			tab_d[tab_addr] <= tab_data;
		end
	end

	assign gate_out = gate_reg;
	assign aux_out = aux_reg;
	assign readout_req = readout_reg;
	assign busy = busy_reg;
	assign frame_index = frame_reg;

	// ==========================================
	// checks
	a_ddg_mode_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_IDLE && fire && !gate_mode_ddg) |=> (sets_left_reg == '0 && !fill_reg))
		else $error("pulse train armed outside generator gate mode");

	a_single_readout: assert property (@(posedge ref_clk) disable iff (!rst_n)
		readout_req |-> ($past(expo_prev_reg) && !$past(exposure_on)) ##1 !readout_req)
		else $error("readout not a single pulse at exposure end");

	a_first_set_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_IDLE && fire && !ext_trig_mode) |=> (state_reg == S_RUN && t_reg == '0))
		else $error("first set not started by exposure strobe");

	a_gate_opens: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_RUN && ch_enable[0] && t_reg == start_reg[0] && end_reg[0] > start_reg[0]) |=> gate_out)
		else $error("gate did not open at its programmed delay");

	a_period_floor: assert property (@(posedge ref_clk) disable iff (!rst_n)
		eff_period >= span)
		else $error("repetition period shorter than pulse span");

	a_set_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_RUN && $past(state_reg) == S_RUN && t_reg < $past(t_reg))
		|-> ({1'b0, $past(t_reg)} >= $past(wrap_at)))
		else $error("pulse set restarted before one period");

	a_count_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_RUN && $past(state_reg) == S_RUN) |-> (sets_left_reg <= $past(sets_left_reg)))
		else $error("pulse set count grew during a train");

	a_extra_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(fire && mpi_on) |=> (start_reg[0] >= TW'(gate_seq_pkg::MPI_EXTRA_CYC)))
		else $error("internal train missing extra delay");

	a_ext_one_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ext_start) |=> (sets_left_reg == '0 && !fill_reg))
		else $error("external trigger armed more than one set");

	a_frame_one_base: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(frame_reg == gate_seq_pkg::FRAME_RST) |-> (step_d == '0 && step_w == '0))
		else $error("first frame carries a step");

	a_no_overrun: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_RUN && $past(state_reg) == S_RUN && t_reg < $past(t_reg)) |-> $past(remain_reg) > $past(span))
		else $error("pulse set started past exposure end");

	a_aux_opens: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_RUN && ch_enable[1] && t_reg == start_reg[1] && end_reg[1] > start_reg[1]) |=> aux_out[0])
		else $error("aux output did not open at its programmed delay");

	a_gate_closes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_RUN && t_reg == end_reg[0]) |=> !gate_out)
		else $error("gate still open past its programmed width");

	a_ext_start_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ext_start |=> (state_reg == S_RUN && t_reg == '0))
		else $error("external edge did not start a set");

	a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == S_IDLE && $past(state_reg) == S_IDLE) |-> !gate_out)
		else $error("gate open while no train runs");

	a_frame_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(fire && kinetic_series && !series_start && frame_reg != '1) |=> (frame_index == $past(frame_reg) + 6'h01))
		else $error("frame index did not advance on exposure");

	a_series_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
		series_start |=> (frame_index == gate_seq_pkg::FRAME_RST))
		else $error("series start did not return to frame one");

	a_const_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(fire && kinetic_series && !series_start) |=> (acc_d_reg == $past(acc_d_reg) + $past(delay_step_inc)))
		else $error("constant delay step not accumulated");
endmodule

/* testbench/ext_trigger_source.sv */
// behavioural external trigger source: three edges per armed exposure
// assumes arm rises with the exposure and drops at its end
`timescale 1ns/1ps
module ext_trigger_source (
	// clock
	input wire logic ref_clk,
	// control
	input wire logic arm,
	input wire logic idle_high,
	// trigger line
	output logic trig
);
	// ==========================================
	// edge generator
	initial trig = 1'b0;
	always begin
		@(posedge ref_clk);
		trig <= idle_high;
		if (arm) begin
			// edges 27 cycles apart so each one-set train is idle again before the next edge
			repeat (3) begin
				repeat (5) @(posedge ref_clk);
				trig <= ~idle_high;
				repeat (2) @(posedge ref_clk);
				trig <= idle_high;
				repeat (20) @(posedge ref_clk);
			end
			while (arm) @(posedge ref_clk);
		end
	end
endmodule

/* testbench/gate_pulse_train_and_step_tb_top.sv */
// testbench for the gate pulse sequencer: trains, spacing, triggers, stepping
// assumes the design's one-cycle fire and one-cycle output register latency
`timescale 1ns/1ps
module gate_pulse_train_and_step_tb_top;
	// ==========================================
	// signals
	logic ref_clk, rst_n, gate_mode_ddg, multi_pulse_integration, ext_trig_mode, ext_edge_falling;
	logic fill_exposure_option, kinetic_series, series_start, tab_we, tab_width_sel, exposure_on, ext_trig_in;
	logic arm, gate_out, readout_req, busy;
	logic [gate_seq_pkg::PC_W-1:0] pulse_set_count;
	logic [gate_seq_pkg::TW-1:0] period_steps, exposure_cycles;
	logic [gate_seq_pkg::CHANS-1:0] ch_enable, ch_step_enable;
	logic [gate_seq_pkg::CHANS-1:0][gate_seq_pkg::TW-1:0] ch_delay, ch_width;
	logic [1:0] delay_step_mode, width_step_mode;
	logic signed [gate_seq_pkg::TW-1:0] delay_step_inc, width_step_inc, tab_data;
	logic [gate_seq_pkg::FRAME_W-1:0] tab_addr, frame_index;
	logic [gate_seq_pkg::AUX-1:0] aux_out;
	int fails, compares, rises, first, wid, gap, last, aux_first, reads;
	logic bz;

	gate_pulse_train_and_step dut (.ref_clk, .rst_n, .gate_mode_ddg, .multi_pulse_integration, .ext_trig_mode,
		.ext_edge_falling, .fill_exposure_option, .pulse_set_count, .period_steps, .exposure_cycles, .ch_enable,
		.ch_step_enable, .ch_delay, .ch_width, .kinetic_series, .series_start, .delay_step_mode, .width_step_mode,
		.delay_step_inc, .width_step_inc, .tab_we, .tab_width_sel, .tab_addr, .tab_data, .exposure_on,
		.ext_trig_in, .gate_out, .aux_out, .readout_req, .busy, .frame_index);
	ext_trigger_source src (.ref_clk, .arm, .idle_high(ext_edge_falling), .trig(ext_trig_in));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic cfg(input logic delay_pulse_generator, input logic ext, input logic fill, input logic [7:0] cnt,
		input logic [23:0] per, input logic [3:0] en);
		@(posedge ref_clk);
		gate_mode_ddg <= delay_pulse_generator;
		multi_pulse_integration <= 1'b1;
		ext_trig_mode <= ext;
		fill_exposure_option <= fill;
		pulse_set_count <= cnt;
		period_steps <= per;
		ch_enable <= en;
	endtask

	// exposure of len cycles; records gate rises, first width, spacing, aux and readout
	task automatic expose(input int len);
		logic prev;
		prev = 1'b0;
		rises = 0;
		wid = 0;
		gap = 0;
		aux_first = 0;
		reads = 0;
		exposure_on <= 1'b1;
		exposure_cycles <= 24'(len);
		arm <= 1'b1;
		for (int n = 1; n <= len + 8; n++) begin
			@(posedge ref_clk);
			if (n == len) begin
				exposure_on <= 1'b0;
				arm <= 1'b0;
			end
			#1;
			if (gate_out === 1'b1 && prev !== 1'b1) begin
				if (rises == 0) first = n;
				else gap = n - last;
				last = n;
				rises++;
			end
			if (gate_out === 1'b1 && rises == 1) wid++;
			if (aux_out[0] === 1'b1 && aux_first == 0) aux_first = n;
			if (readout_req === 1'b1) reads++;
			if (n == 2) bz = busy;
			prev = gate_out;
		end
	endtask

	// ==========================================
	// scenarios
	task automatic counted_train();
		cfg(1'b1, 1'b0, 1'b0, 8'h03, 24'h00000A, 4'h1);
		expose(120);
		check(rises, 3);
		check(first, 8);
		check(wid, 3);
		check(gap, 20);
		check(reads, 1);
		check(bz, 1);
		check(busy, 0);
	endtask

	task automatic span_raise();
		cfg(1'b1, 1'b0, 1'b0, 8'h04, 24'h000001, 4'h3);
		expose(60);
		check(rises, 4);
		check(gap, 7);
		check(aux_first, 4);
	endtask

	task automatic not_ddg();
		cfg(1'b0, 1'b0, 1'b0, 8'h03, 24'h00000A, 4'h1);
		expose(60);
		check(rises, 1);
		check(first, 6);
	endtask

	task automatic fill_train();
		cfg(1'b1, 1'b0, 1'b1, 8'h01, 24'h00000A, 4'h1);
		expose(100);
		check(rises, 5);
		check(gap, 20);
	endtask

	task automatic ext_train();
		cfg(1'b1, 1'b1, 1'b0, 8'h05, 24'h00000A, 4'h1);
		ext_edge_falling <= 1'b1;
		repeat (3) @(posedge ref_clk);
		expose(90);
		check(rises, 3);
		check(first, 12);
		check(wid, 3);
		ext_edge_falling <= 1'b0;
	endtask

	// host-loaded width steps are 2, 4 for frames two and three; frame one keeps the base width
	task automatic kinetic(input int inc, input logic kin);
		cfg(1'b1, 1'b0, 1'b0, 8'h01, 24'h000001, 4'h1);
		for (int k = 1; k < 3; k++) begin
			@(posedge ref_clk);
			tab_we <= 1'b1;
			tab_width_sel <= 1'b1;
			tab_addr <= 6'(k);
			tab_data <= 24'(2 * k);
		end
		@(posedge ref_clk);
		tab_we <= 1'b0;
		multi_pulse_integration <= 1'b0;
		ch_step_enable <= 4'h1;
		delay_step_mode <= gate_seq_pkg::STEP_CONST;
		width_step_mode <= gate_seq_pkg::STEP_EXP;
		delay_step_inc <= 24'(inc);
		kinetic_series <= kin;
		series_start <= 1'b1;
		@(posedge ref_clk);
		series_start <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			expose(30);
			check(first, 6 + (kin ? k * inc : 0));
			check(wid, 3 + (kin ? 2 * k : 0));
		end
		check(frame_index, kin ? 3 : 0);
	endtask

	// ==========================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		{gate_mode_ddg, multi_pulse_integration, ext_trig_mode, ext_edge_falling} = 4'h0;
		{fill_exposure_option, kinetic_series, series_start, tab_we, tab_width_sel} = 5'h00;
		{exposure_on, arm} = 2'h0;
		pulse_set_count = 8'h01;
		period_steps = 24'h000001;
		exposure_cycles = 24'h000000;
		ch_enable = 4'h1;
		ch_step_enable = 4'h0;
		ch_delay = {24'h000000, 24'h000000, 24'h000000, 24'h000004};
		ch_width = {24'h000002, 24'h000002, 24'h000002, 24'h000003};
		delay_step_mode = gate_seq_pkg::STEP_OFF;
		width_step_mode = gate_seq_pkg::STEP_OFF;
		{delay_step_inc, width_step_inc, tab_data} = 72'h0;
		tab_addr = 6'h00;
		fails = 0;
		compares = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		counted_train();
		span_raise();
		not_ddg();
		fill_train();
		ext_train();
		kinetic(3, 1'b1);
		kinetic(-1, 1'b1);
		kinetic(3, 1'b0);
		complete_run();
	end
endmodule
